// ---- core/mcg_edge.sv ----
// Marker input edge detector with selectable active edge.
`timescale 1ns/1ps
`default_nettype none
module mcg_edge #(
	parameter int N = 4
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [N-1:0] i_level,
	input wire logic i_fall,
	output logic [N-1:0] o_event
);
	import mcg_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [N-1:0] prev_q;
		logic [N-1:0] evt_q;
	} mcg_edge_st_s;

	mcg_edge_st_s st_q;
	mcg_edge_st_s st_d;

	// Per bit compare of this and last level; the prior level resets low so a low input never fires.
	always_comb begin
		st_d = st_q;
		st_d.prev_q = i_level;
		for (int k = 0; k < N; k++) begin
			st_d.evt_q[k] = i_fall ? (st_q.prev_q[k] & ~i_level[k])
				: (~st_q.prev_q[k] & i_level[k]);
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_event = st_q.evt_q;
endmodule : mcg_edge
`default_nettype wire

// ---- core/mcg_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module mcg_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	import mcg_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem_q;
		logic [AW-1:0] wr_q;
		logic [AW-1:0] rd_q;
		logic [AW:0] cnt_q;
	} mcg_fifo_st_s;

	mcg_fifo_st_s st_q;
	mcg_fifo_st_s st_d;
	logic push;
	logic pop;

	// Honest full and empty come from the fill count.
	assign o_ready = (st_q.cnt_q != (AW+1)'(DEPTH));
	assign o_valid = (st_q.cnt_q != '0);
	assign o_data = st_q.mem_q[st_q.rd_q];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;

	// Pointer and count update.
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem_q[st_q.wr_q] = i_data;
			st_d.wr_q = (st_q.wr_q == AW'(DEPTH-1)) ? '0 : st_q.wr_q + 1'b1;
		end
		if (pop) begin
			st_d.rd_q = (st_q.rd_q == AW'(DEPTH-1)) ? '0 : st_q.rd_q + 1'b1;
		end
		if (push && !pop) begin
			st_d.cnt_q = st_q.cnt_q + 1'b1;
		end else if (pop && !push) begin
			st_d.cnt_q = st_q.cnt_q - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : mcg_fifo
`default_nettype wire

// ---- core/mcg_pkg.sv ----
// Package with constants, register map and carrier types for the marker and count gating block.
package mcg_pkg;

	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int MCG_MARKERS = 4;
	localparam int MCG_ROUTES = 3;
	localparam int MCG_TAG_W = 24;
	localparam int MCG_REC_W = 32;
	localparam int MCG_FIFO_DEPTH = 8;
	localparam int MCG_CLK_MHZ = 20;
	localparam int MCG_MARK_MIN_NS = 100;
	// Least level time in cycles, rounded up, at least one.
	localparam int MCG_MARK_MIN_CYC = (MCG_MARK_MIN_NS * MCG_CLK_MHZ + 999) / 1000;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] MCG_CTRL_OFF = 12'h000;
	localparam logic [11:0] MCG_STAT_OFF = 12'h004;
	localparam logic [11:0] MCG_MCNT_OFF = 12'h008;
	localparam logic [11:0] MCG_PDROP_OFF = 12'h00c;
	// Control field positions.
	localparam int MCG_CTRL_RUN = 0;
	localparam int MCG_CTRL_TT = 1;
	localparam int MCG_CTRL_FALL = 2;
	localparam int MCG_CTRL_MEN = 4;
	localparam logic [31:0] MCG_CTRL_RST = 32'h0000_00f0;
	localparam logic [31:0] MCG_ZERO = 32'h0000_0000;

	// ****************************************
	// Record layout
	// ****************************************
	localparam logic MCG_KIND_PHOTON = 1'b0;
	localparam logic MCG_KIND_MARKER = 1'b1;

	// One output record.
	typedef struct packed {
		logic kind;
		logic [2:0] route;
		logic [3:0] markers;
		logic [MCG_TAG_W-1:0] tag;
	} mcg_rec_s;

	// APB request carrier.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mcg_apb_req_s;

	// APB answer carrier.
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mcg_apb_rsp_s;

endpackage : mcg_pkg

// ---- core/mcg_top.sv ----
// Marker insertion, count gating and route selection with an APB register file.
//
// Contract
// (RULE1) Four marker bits 0..3 are recorded only in time tagged mode.
// (RULE2) Markers fire on one software-chosen edge, rising or falling.
// (RULE3) An open marker input reads low and never fires.
// (RULE4) The source holds each marker level at least 100 ns.
// (RULE5) Each marker event inserts one extra record into the stream.
// (RULE6) Markers win the stream; photons may be dropped.
// (RULE7) The source limits marker traffic, e.g. line clock only.
// (RULE8) Control connector markers work in parallel with router connector markers.
// (RULE9) Measurement-active output is high exactly while a measurement runs; here it follows the run bit one cycle late.
// (RULE10) Count enable gates photon recording in every mode.
// (RULE11) With a router attached only the router drives count enable.
// (RULE12) Router detect high selects routing from the control connector.
// (RULE13) The router supplies three route signals numbered 1 to 3.
// (RULE14) Count enable is active high; held high leaves counting on.
// (RULE15) Marker records carry the time tag and the active marker bits.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module mcg_top (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire mcg_pkg::mcg_apb_req_s i_apb,
	output mcg_pkg::mcg_apb_rsp_s o_apb,
	input wire logic [mcg_pkg::MCG_MARKERS-1:0] i_marker_ctrl,
	input wire logic [2:0] i_marker_router,
	input wire logic i_count_en_ctrl,
	input wire logic i_count_en_router,
	input wire logic i_router_detect,
	input wire logic [mcg_pkg::MCG_ROUTES-1:0] i_route_ctrl,
	input wire logic [mcg_pkg::MCG_ROUTES-1:0] i_route_router,
	input wire logic i_photon,
	output logic o_meas_active,
	output logic o_rec_valid,
	input wire logic i_rec_ready,
	output mcg_pkg::mcg_rec_s o_rec
);
	import mcg_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] ctrl_q;
		logic [MCG_TAG_W-1:0] tag_q;
		logic [31:0] mcnt_q;
		logic [31:0] pdrop_q;
		mcg_apb_rsp_s apb_q;
		logic act_q;
		logic out_valid_q;
		mcg_rec_s out_q;
	} mcg_st_s;

	mcg_st_s st_q;
	mcg_st_s st_d;

	logic [MCG_MARKERS-1:0] mark_lvl;
	logic [MCG_MARKERS-1:0] mark_evt;
	logic run;
	logic tt_mode;
	logic count_en;
	logic [MCG_ROUTES-1:0] route_sel;
	logic mark_hit;
	logic phot_hit;
	logic in_valid;
	logic in_ready;
	mcg_rec_s in_rec;
	logic f_valid;
	logic f_ready;
	logic [MCG_REC_W-1:0] f_data;
	logic acc;
	logic wr;

	assign run = st_q.ctrl_q[MCG_CTRL_RUN];
	assign tt_mode = st_q.ctrl_q[MCG_CTRL_TT];

	// ****************************************
	// Input selection
	// ****************************************

	// (RULE8) parallel marker sources
	// Both connectors feed the same bits; bit 3 exists only on the control connector.
	assign mark_lvl = (i_marker_ctrl | {1'b0, i_marker_router})
		& st_q.ctrl_q[MCG_CTRL_MEN +: MCG_MARKERS];

	// (RULE11) router owns enable
	// With a router attached its enable line is used and the external one is ignored.
	// (RULE14) active high enable
	assign count_en = i_router_detect ? i_count_en_router : i_count_en_ctrl;

	// (RULE12) route source select
	assign route_sel = i_router_detect ? i_route_ctrl : i_route_router;

	// (RULE2) selectable edge
	// (RULE3) pulled-down inputs
	mcg_edge #(
		.N(MCG_MARKERS)
	) u_edge (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_level(mark_lvl),
		.i_fall(st_q.ctrl_q[MCG_CTRL_FALL]),
		.o_event(mark_evt)
	);

	// ****************************************
	// Record arbitration
	// ****************************************

	// (RULE1) time tagged only
	assign mark_hit = run & tt_mode & (|mark_evt);
	// (RULE10) count gating
	assign phot_hit = run & count_en & i_photon;

	// (RULE6) marker priority
	// A marker takes the slot; a photon in the same cycle is dropped.
	always_comb begin
		in_rec = '0;
		in_rec.tag = st_q.tag_q;
		in_rec.route = route_sel;
		if (mark_hit) begin
			// (RULE15) tag and bits
			in_rec.kind = MCG_KIND_MARKER;
			in_rec.markers = mark_evt;
			in_rec.route = '0;
		end else begin
			in_rec.kind = MCG_KIND_PHOTON;
		end
	end

	// (RULE5) one record per event
	assign in_valid = mark_hit | phot_hit;

	mcg_fifo #(
		.W(MCG_REC_W),
		.DEPTH(MCG_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_valid(in_valid),
		.o_ready(in_ready),
		.i_data(in_rec),
		.o_valid(f_valid),
		.i_ready(f_ready),
		.o_data(f_data)
	);

	// Output stage register loads the FIFO head whenever it is empty or the consumer takes it.
	assign f_ready = !st_q.out_valid_q || i_rec_ready;

	// ****************************************
	// APB slave
	// ****************************************
	assign acc = i_apb.psel & i_apb.penable;
	assign wr = acc & i_apb.pwrite;

	// Next state of the whole block.
	always_comb begin
		st_d = st_q;
		st_d.tag_q = run ? st_q.tag_q + 1'b1 : '0;
		// (RULE9) measurement active
		st_d.act_q = run;
		// Marker count and photon loss statistics.
		if (mark_hit && in_ready) begin
			st_d.mcnt_q = st_q.mcnt_q + 32'h0000_0001;
		end
		if ((phot_hit && mark_hit) || (in_valid && !in_ready && phot_hit)) begin
			st_d.pdrop_q = st_q.pdrop_q + 32'h0000_0001;
		end
		// Output stage.
		if (f_ready) begin
			st_d.out_valid_q = f_valid;
			st_d.out_q = f_data;
		end
		// One-wait answer: pready rises one cycle into the access phase.
		st_d.apb_q.pready = acc & !st_q.apb_q.pready;
		st_d.apb_q.pslverr = 1'b0;
		st_d.apb_q.prdata = MCG_ZERO;
		if (acc && !st_q.apb_q.pready) begin
			case (i_apb.paddr)
				MCG_CTRL_OFF: begin
					st_d.apb_q.prdata = st_q.ctrl_q;
				end
				MCG_STAT_OFF: begin
					st_d.apb_q.prdata = {22'h00_0000, i_router_detect, count_en,
						mark_lvl, st_q.out_valid_q, !in_ready, 1'b0, st_q.act_q};
				end
				MCG_MCNT_OFF: begin
					st_d.apb_q.prdata = st_q.mcnt_q;
				end
				MCG_PDROP_OFF: begin
					st_d.apb_q.prdata = st_q.pdrop_q;
				end
				default: begin
					st_d.apb_q.pslverr = 1'b1;
				end
			endcase
		end
		// Writes commit only at the edge where the master sees pready high.
		if (wr && st_q.apb_q.pready) begin
			case (i_apb.paddr)
				MCG_CTRL_OFF: begin
					st_d.ctrl_q = {24'h00_0000, i_apb.pwdata[7:4], 1'b0,
						i_apb.pwdata[2:0]};
				end
				MCG_MCNT_OFF: begin
					st_d.mcnt_q = MCG_ZERO;
				end
				MCG_PDROP_OFF: begin
					st_d.pdrop_q = MCG_ZERO;
				end
				default: begin
					st_d.pdrop_q = st_d.pdrop_q;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
			st_q.ctrl_q <= MCG_CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_apb = st_q.apb_q;
	assign o_meas_active = st_q.act_q;
	assign o_rec_valid = st_q.out_valid_q;
	assign o_rec = st_q.out_q;
endmodule : mcg_top
`default_nettype wire

// ---- tb/mcg_props.sv ----
// Port checker of the marker and count gating block.
`timescale 1ns/1ps
`default_nettype none
module mcg_props (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire mcg_pkg::mcg_apb_req_s i_apb,
	input wire mcg_pkg::mcg_apb_rsp_s o_apb,
	input wire logic o_meas_active,
	input wire logic o_rec_valid,
	input wire logic i_rec_ready,
	input wire mcg_pkg::mcg_rec_s o_rec
);
	import mcg_pkg::*;
	// ****************
	// Properties
	// ****************
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	a_ready_once: assert property (o_apb.pready |=> !o_apb.pready)
		else $error("pready held too long");
	a_ready_wait: assert property (i_apb.psel && $rose(i_apb.penable) |=> o_apb.pready)
		else $error("pready late");
	a_err_paired: assert property (o_apb.pslverr |-> o_apb.pready)
		else $error("pslverr without pready");
	a_run_follow: assert property (i_apb.psel && i_apb.pwrite && o_apb.pready &&
		i_apb.paddr == MCG_CTRL_OFF |-> ##2 o_meas_active == $past(i_apb.pwdata[0], 2))
		else $error("active output wrong");
	a_rec_hold: assert property (o_rec_valid && !i_rec_ready |=> o_rec_valid && $stable(o_rec))
		else $error("record not held");
	a_mark_bits: assert property (o_rec_valid && o_rec.kind |-> o_rec.markers != 4'h0)
		else $error("marker record without bits");
	a_mark_route: assert property (o_rec_valid && o_rec.kind |-> o_rec.route == 3'h0)
		else $error("marker record with route");
	a_photon_clean: assert property (o_rec_valid && !o_rec.kind |-> o_rec.markers == 4'h0)
		else $error("photon record with bits");
	c_mark: cover property (o_rec_valid && i_rec_ready && o_rec.kind);
	c_photon: cover property (o_rec_valid && i_rec_ready && !o_rec.kind);
	c_err: cover property (o_apb.pslverr);
endmodule : mcg_props
`default_nettype wire

// ---- tb/mcg_src.sv ----
// Model of the marker source and the router accessory.
`timescale 1ns/1ps
`default_nettype none
module mcg_src (
	input wire logic i_core_clk,
	input wire logic [3:0] i_go,
	input wire logic i_rtr,
	input wire logic i_cv,
	output logic [3:0] o_mk_ctrl,
	output logic [2:0] o_mk_rtr,
	output logic o_det,
	output logic o_cen,
	output logic [2:0] o_route
);
	import mcg_pkg::*;
	logic [3:0] lv = '0;
	int cnt = 0;
	// held sparse levels
	// A pulse stays high, then low, longer than the least level time.
	always @(posedge i_core_clk) begin
		if (cnt > 0) cnt <= cnt - 1;
		if (cnt == MCG_MARK_MIN_CYC + 2) lv <= '0;
		if (cnt == 0 && i_go != 0) begin
			lv <= i_go;
			cnt <= 2 * MCG_MARK_MIN_CYC + 3;
		end
	end
	// router wiring
	// Bits 2..0 move to the router connector while it is attached; idle lines sit low.
	assign o_mk_ctrl = i_rtr ? {lv[3], 3'h0} : lv;
	assign o_mk_rtr = i_rtr ? lv[2:0] : 3'h0;
	assign o_det = i_rtr;
	assign o_cen = i_cv;
	assign o_route = 3'h5;
endmodule : mcg_src
`default_nettype wire

// ---- tb/mcg_top_tb.sv ----
// Self-checking bench of the marker and count gating block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module mcg_top_tb;
	import mcg_pkg::*;
	// ****************
	// Signals and model state
	// ****************
	logic i_core_clk = 0, i_rst = 1, i_photon = 0, i_rec_ready = 1, i_count_en_ctrl = 1;
	logic rtr = 0, cv = 1, er, o_meas_active, o_rec_valid, i_router_detect, i_count_en_router;
	logic [3:0] go = 0, i_marker_ctrl;
	logic [2:0] i_route_ctrl = 0, i_marker_router, i_route_router;
	logic [31:0] rd, ctl = MCG_CTRL_RST;
	logic [7:0] lf = 8'h2b, ex;
	logic [7:0] exp_q[$];
	int n_fail = 0, n_compared = 0, cyc = 0;
	mcg_apb_req_s i_apb = '0;
	mcg_apb_rsp_s o_apb;
	mcg_rec_s o_rec;
	// Far side model and the block.
	mcg_src mcg_src_i (.i_core_clk, .i_go(go), .i_rtr(rtr), .i_cv(cv), .o_mk_ctrl(i_marker_ctrl),
		.o_mk_rtr(i_marker_router), .o_det(i_router_detect), .o_cen(i_count_en_router),
		.o_route(i_route_router));
	mcg_top mcg_top_i (.*);
	// Clock of 50 ns period.
	always #25 i_core_clk = ~i_core_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_core_clk);
		i_apb.penable <= 1'b1;
		do @(posedge i_core_clk); while (o_apb.pready !== 1'b1);
		rd = o_apb.prdata;
		er = o_apb.pslverr;
		i_apb <= '0;
	endtask : apb
	task automatic cset(input logic [31:0] v);
		apb(1'b1, MCG_CTRL_OFF, v);
		ctl = v;
	endtask : cset
	// One marker pulse; a record is due in time tagged mode on enabled bits.
	task automatic mk(input logic [3:0] b);
		go <= b;
		@(posedge i_core_clk);
		go <= '0;
		if (ctl[0] & ctl[1] & |(b & ctl[7:4])) exp_q.push_back({4'h8, b & ctl[7:4]});
		repeat (8) @(posedge i_core_clk);
	endtask : mk
	// One photon; a record is due while running with the selected enable high.
	task automatic pho;
		i_photon <= 1'b1;
		@(posedge i_core_clk);
		i_photon <= 1'b0;
		if (ctl[0] & (rtr ? cv : i_count_en_ctrl))
			exp_q.push_back({1'b0, rtr ? i_route_ctrl : 3'h5, 4'h0});
		@(posedge i_core_clk);
	endtask : pho
	// Record compare at each accepted output, and the run limit.
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out;
		end
		if (o_rec_valid & i_rec_ready & !i_rst) begin
			ex = exp_q.size() ? exp_q.pop_front() : 8'hff;
			`CHK("record", ex, {o_rec.kind, o_rec.route, o_rec.markers})
		end
	end
	// Main sequence.
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		apb(1'b0, MCG_CTRL_OFF, 0);
		`CHK("ctrl", MCG_CTRL_RST, rd)
		apb(1'b1, 12'h010, 32'h1);
		`CHK("slverr", 1'b1, er)
		cset(32'h0000_00f3);
		repeat (3) @(posedge i_core_clk);
		`CHK("active", 1'b1, o_meas_active)
		for (int b = 0; b < 4; b++) mk(4'h1 << b);
		rtr <= 1'b1;
		for (int b = 0; b < 3; b++) mk(4'h1 << b);
		rtr <= 1'b0;
		mk(4'hf);
		cset(32'h0000_00e3);
		mk(4'h1);
		mk(4'h2);
		cset(32'h0000_00f7);
		mk(4'h4);
		cset(32'h0000_00f1);
		mk(4'h1);
		cset(32'h0000_00f3);
		for (int i = 0; i < 4; i++) begin
			i_count_en_ctrl <= i[0];
			cv <= !i[0];
			rtr <= i[1];
			lf = lfsr(lf);
			i_route_ctrl <= lf[2:0];
			@(posedge i_core_clk);
			pho;
		end
		i_count_en_ctrl <= 1'b1;
		rtr <= 1'b0;
		i_rec_ready <= 1'b0;
		@(posedge i_core_clk);
		repeat (12) pho;
		repeat (3) void'(exp_q.pop_back());
		apb(1'b0, MCG_STAT_OFF, 0);
		`CHK("full", 1'b1, rd[2])
		apb(1'b0, MCG_PDROP_OFF, 0);
		`CHK("dropped", 32'h3, rd)
		i_rec_ready <= 1'b1;
		repeat (20) @(posedge i_core_clk);
		cset(32'h0000_00f0);
		repeat (3) @(posedge i_core_clk);
		`CHK("active", 1'b0, o_meas_active)
		`CHK("left", 32'h0, 32'(exp_q.size()))
		close_out;
	end
endmodule : mcg_top_tb
bind mcg_top mcg_props mcg_props_i (.*);
`default_nettype wire
